// *** bench/fwps_host.sv ***
// host controller model driving the serial flash link
`timescale 1ns/100ps
`default_nettype none
module fwps_host (
	input  wire logic       clk_sys_i,
	input  wire logic       spi_so_i,
	output var  logic       spi_cs_n_o,
	output var  logic       spi_sclk_o,
	output var  logic       spi_si_o,
	output var  logic       rd_valid_o,
	output var  logic [7:0] rd_byte_o
);
	initial begin
		spi_cs_n_o = 1'b1;
		spi_sclk_o = 1'b0;
		spi_si_o   = 1'b0;
		rd_valid_o = 1'b0;
		rd_byte_o  = 8'h00;
	end
	// data line toggles while deselected, so no stale bit is trusted
	always @(posedge clk_sys_i) begin
		if (spi_cs_n_o)
			spi_si_o <= ~spi_si_o;
	end
	////////////////////////////////////////////////////////////////////
	// one serial clock of 80 ns, sampling the output at the rise
	task automatic bit_io(input logic b, output logic s);
		spi_si_o <= b;
		repeat (10) @(posedge clk_sys_i);
		spi_sclk_o <= 1'b1;
		s = spi_so_i;
		repeat (10) @(posedge clk_sys_i);
		spi_sclk_o <= 1'b0;
	endtask : bit_io
	// one frame: n bytes out msb first, then an optional byte in
	task automatic frame(input int n, input logic [63:0] tx, input bit rd);
		logic       s;
		logic [7:0] r;
		r = 8'h00;
		s = 1'b0;
		@(posedge clk_sys_i);
		spi_cs_n_o <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		for (int i = n * 8 - 1; i >= 0; i--)
			bit_io(tx[i], s);
		if (rd) begin
			for (int i = 0; i < 8; i++) begin
				bit_io(~s, s);
				r = {r[6:0], s};
			end
			rd_byte_o  <= r;
			rd_valid_o <= 1'b1;
		end
		@(posedge clk_sys_i);
		rd_valid_o <= 1'b0;
		repeat (9) @(posedge clk_sys_i);
		spi_cs_n_o <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
	endtask : frame
endmodule : fwps_host
`default_nettype wire

// *** bench/tb.sv ***
// self-checking testbench of the write-protect and status block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fwps_pkg::*;
	localparam int PUW = 400;
	logic            clk_sys_i, reset_i, op_done_i, done_hold;
	logic            cs_n, sclk, si, so, op_start, dvalid, busy, rd_valid;
	logic            so_raw, so_oe, pd;
	logic [7:0]      rd_byte, op_data, e_b;
	logic [31:0]     op_addr, seed, a, r;
	logic [35:0]     e_op, g_op;
	fwps_op_t        op_kind;
	int              err_count, compares, dcnt;
	logic [35:0]     exp_op[$];
	logic [7:0]      exp_rd[$], exp_dat[$];
	fwps_op_t        kinds[4] = '{OPK_PROG, OPK_SECT, OPK_BLK, OPK_CHIP};
	logic [7:0]      ops[4] = '{8'h02, 8'h20, 8'hD8, 8'hC7};
	int              nb[4] = '{6, 5, 5, 1};
	logic [7:0]      sr1[4] = '{8'h04, 8'h44, 8'h04, 8'h28};
	logic [7:0]      sr2[4] = '{8'h02, 8'h02, 8'h42, 8'h02};
	logic [8:0]      blk_no[4] = '{9'h1FF, 9'h000, 9'h000, 9'h100};
	logic [8:0]      blk_ok[4] = '{9'h1FE, 9'h001, 9'h1FF, 9'h0FF};

	fwps_top #(.PUW_CYCLES(PUW)) u_fwps_top (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .ce_i(1'b1), .spi_cs_n_i(cs_n),
		.spi_sclk_i(sclk), .spi_si_i(si), .spi_so_o(so_raw),
		.spi_so_oe_o(so_oe),
		.op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr),
		.op_data_o(op_data), .op_data_valid_o(dvalid),
		.op_done_i(op_done_i), .busy_o(busy), .power_down_o(pd));
	// released data line shows the inverse of its last driven level
	assign so = so_oe ? so_raw : ~so_raw;
	fwps_host u_fwps_host (.clk_sys_i(clk_sys_i), .spi_so_i(so),
		.spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_si_o(si),
		.rd_valid_o(rd_valid), .rd_byte_o(rd_byte));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic fail(input logic [35:0] got, input logic [35:0] exp);
		err_count++;
		$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
	endtask : fail
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		compares++;
		if (got !== exp) fail(got, exp);
	endtask : chk
	task automatic conclude();
		if (exp_op.size() + exp_rd.size() + exp_dat.size() != 0)
			err_count++;
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic cmd(input int n, input logic [63:0] tx);
		u_fwps_host.frame(n, tx, 1'b0);
	endtask : cmd
	task automatic rd(input logic [7:0] op, input logic [7:0] e);
		exp_rd.push_back(e);
		u_fwps_host.frame(1, {56'h0, op}, 1'b1);
	endtask : rd
	task automatic wren();
		cmd(1, 64'h06);
	endtask : wren
	task automatic idle();
		int i;
		for (i = 0; i < 300 && busy !== 1'b0; i++)
			@(posedge clk_sys_i);
		if (i == 300) begin
			fail(busy, 0);
			conclude();
		end
	endtask : idle
	task automatic wsr(input int n, input logic [63:0] tx);
		wren();
		exp_op.push_back({1'b0, OPK_STAT, 32'h0});
		cmd(n, tx);
		idle();
	endtask : wsr
	task automatic try_se(input logic [31:0] ad, input bit ok);
		wren();
		if (ok)
			exp_op.push_back({1'b1, OPK_SECT, ad});
		cmd(5, {24'h0, 8'h20, ad});
		idle();
	endtask : try_se
	////////////////////////////////////////////////////////////////////
	// array side: finishes each started operation after a random delay
	always @(posedge clk_sys_i) begin
		op_done_i <= op_start !== 1'b1 && dcnt == 1 && !done_hold;
		if (op_start === 1'b1)
			dcnt <= 2 + int'(xs() & 32'hF);
		else if (dcnt > 0 && !done_hold)
			dcnt <= dcnt - 1;
	end
	// result watcher: each result takes the oldest expectation
	always @(posedge clk_sys_i) begin
		if (op_start === 1'b1) begin
			compares++;
			e_op = exp_op.size() ? exp_op.pop_front() : '1;
			g_op = {e_op[35], op_kind, e_op[35] ? op_addr : 32'h0};
			if (g_op !== e_op) fail(g_op, e_op);
		end
		if (dvalid === 1'b1) begin
			compares++;
			e_b = exp_dat.size() ? exp_dat.pop_front() : ~op_data;
			if (op_data !== e_b) fail(op_data, e_b);
		end
		if (rd_valid === 1'b1) begin
			compares++;
			e_b = exp_rd.size() ? exp_rd.pop_front() : ~rd_byte;
			if (rd_byte !== e_b) fail(rd_byte, e_b);
		end
	end
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h6aa84d1f;
		reset_i = 1'b1;
		op_done_i = 1'b0;
		done_hold = 1'b0;
		dcnt = 0;
		err_count = 0;
		compares = 0;
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		wren();
		rd(8'h05, 8'h00);
		rd(8'h35, 8'h02);
		rd(8'h15, 8'h00);
		cmd(5, {24'h0, 8'h20, 32'h00100000});
		rd(8'h05, 8'h00);
		wren();
		rd(8'h05, 8'h02);
		cmd(1, 64'h04);
		rd(8'h05, 8'h00);
		// busy window held open by the array side
		done_hold <= 1'b1;
		wren();
		a = xs() & 32'h01FFFFFF;
		exp_op.push_back({1'b1, OPK_SECT, a});
		cmd(5, {24'h0, 8'h20, a});
		rd(8'h05, 8'h01);
		wren();
		done_hold <= 1'b0;
		idle();
		rd(8'h05, 8'h00);
		// every program and erase operation kind
		for (int k = 0; k < 4; k++) begin
			r = xs();
			a = {7'h0, r[24:0]};
			wren();
			exp_op.push_back({k != 3, kinds[k], k != 3 ? a : 32'h0});
			if (k == 0)
				exp_dat.push_back(r[31:24]);
			cmd(nb[k], {16'h0, ops[k], a, r[31:24]} >> (8 * (6 - nb[k])));
			idle();
			rd(8'h05, 8'h00);
		end
		// range protection table
		for (int k = 0; k < 4; k++) begin
			wsr(3, {40'h0, 8'h01, sr1[k], sr2[k]});
			rd(8'h05, sr1[k]);
			try_se({7'h0, blk_no[k], 16'h0}, 1'b0);
			try_se({7'h0, blk_ok[k], 16'h0} | (xs() & 32'hFFFF), 1'b1);
		end
		wsr(3, 64'h010002);
		// individual lock scheme
		wsr(2, 64'h1104);
		rd(8'h15, 8'h04);
		try_se(32'h00640000, 1'b0);
		cmd(5, {24'h0, 8'h39, 32'h00640000});
		try_se(32'h0064A123, 1'b1);
		try_se(32'h00650000, 1'b0);
		cmd(5, {24'h0, 8'h39, 32'h01FF3000});
		try_se(32'h01FF3ABC, 1'b1);
		try_se(32'h01FF4000, 1'b0);
		// status lock, then power-down lockout
		wsr(2, 64'h3103);
		rd(8'h35, 8'h03);
		wren();
		cmd(2, 64'h0124);
		rd(8'h05, 8'h02);
		cmd(1, 64'hB9);
		chk(pd, 1);
		cmd(1, 64'h04);
		cmd(1, 64'hAB);
		chk(pd, 0);
		rd(8'h05, 8'h02);
		// supply reset in mid-run with a frame during it
		reset_i <= 1'b1;
		wren();
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rd(8'h05, 8'h00);
		rd(8'h35, 8'h02);
		repeat (4) @(posedge clk_sys_i);
		conclude();
	end
endmodule : tb
`default_nettype wire

// *** rtl/fwps_defs.svh ***
// constants of the flash write-protect and status block
`ifndef FWPS_DEFS_SVH
`define FWPS_DEFS_SVH
////////////////////////////////////////////////////////////////////////////
// timing
`define FWPS_CLK_NS      4
`define FWPS_PUW_US      10
////////////////////////////////////////////////////////////////////////////
// instruction opcodes
`define FWPS_OP_WREN     8'h06
`define FWPS_OP_WRDI     8'h04
`define FWPS_OP_RDSR1    8'h05
`define FWPS_OP_RDSR2    8'h35
`define FWPS_OP_RDSR3    8'h15
`define FWPS_OP_WRSR1    8'h01
`define FWPS_OP_WRSR2    8'h31
`define FWPS_OP_WRSR3    8'h11
`define FWPS_OP_PP       8'h02
`define FWPS_OP_SE       8'h20
`define FWPS_OP_BE       8'hD8
`define FWPS_OP_CE       8'hC7
`define FWPS_OP_PD       8'hB9
`define FWPS_OP_RPD      8'hAB
`define FWPS_OP_UNLK     8'h39
`define FWPS_OP_LOCK     8'h36
`define FWPS_OP_SUSP     8'h75
////////////////////////////////////////////////////////////////////////////
// status bit positions
`define FWPS_SR1_BUSY    0
`define FWPS_SR1_WEL     1
`define FWPS_SR1_BP_LO   2
`define FWPS_SR1_BP_HI   5
`define FWPS_SR1_TB      6
`define FWPS_SR2_SRL     0
`define FWPS_SR2_QE      1
`define FWPS_SR2_LB_LO   3
`define FWPS_SR2_LB_HI   5
`define FWPS_SR2_CMP     6
`define FWPS_SR3_WPS     2
////////////////////////////////////////////////////////////////////////////
// array geometry and argument counts
`define FWPS_ADDR_BYTES  3'd4
`define FWPS_BYTE_MAX    3'd7
`define FWPS_BIT_LAST    3'd7
`define FWPS_BLK_HI      24
`define FWPS_BLK_LO      16
`define FWPS_SEC_HI      15
`define FWPS_SEC_LO      12
`define FWPS_NBLK        10'd512
`define FWPS_TOP_BLK     9'h1FF
`define FWPS_BP_SAT      4'd9
`define FWPS_LIDX_W      10
`define FWPS_LOCK_BITS   542
`define FWPS_SEC_PER_END 10'd16
`define FWPS_BLK_BASE    10'd31
`endif

// *** rtl/fwps_lock_if.sv ***
// connection between the protection logic and its lock-bit store
`timescale 1ns/100ps
`default_nettype none
interface fwps_lock_if #(parameter int IW = 10);
	logic [IW-1:0] idx;
	logic          wr;
	logic          wval;
	logic          rdata;
	logic          any;
	modport ctrl (output idx, output wr, output wval, input rdata, input any);
	modport mem  (input idx, input wr, input wval, output rdata, output any);
endinterface : fwps_lock_if
`default_nettype wire

// *** rtl/fwps_lock_mem.sv ***
// individual lock-bit store with registered read
`timescale 1ns/100ps
`default_nettype none
`include "fwps_defs.svh"
module fwps_lock_mem #(
	parameter int NBITS = `FWPS_LOCK_BITS
) (
	input  wire logic clk_sys_i,
	input  wire logic reset_i,
	input  wire logic ce_i,
	fwps_lock_if.mem  lk
);
	logic [NBITS-1:0] bits_reg;
	logic             rdata_reg;
	logic             in_map;
	initial begin
		if (NBITS < 1 || NBITS > (1 << `FWPS_LIDX_W))
			$error("fwps_lock_mem: bit count does not fit index");
	end
	assign in_map = 32'(lk.idx) < NBITS;
	// all bits locked after power-on
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			bits_reg <= '1;
		end else if (ce_i && lk.wr && in_map) begin
			bits_reg[lk.idx] <= lk.wval;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_reg <= 1'b1;
		end else if (ce_i) begin
			rdata_reg <= in_map ? bits_reg[lk.idx] : 1'b1;
		end
	end
	assign lk.rdata = rdata_reg;
	assign lk.any   = |bits_reg;
endmodule : fwps_lock_mem
`default_nettype wire

// *** rtl/fwps_pkg.sv ***
// types of the flash write-protect and status block
package fwps_pkg;
	typedef enum logic [1:0] {
		LNK_IDLE = 2'b00,
		LNK_OPC  = 2'b01,
		LNK_ARG  = 2'b10,
		LNK_SKIP = 2'b11
	} fwps_link_t;
	typedef enum logic [2:0] {
		OPK_PROG = 3'b000,
		OPK_SECT = 3'b001,
		OPK_BLK  = 3'b010,
		OPK_CHIP = 3'b011,
		OPK_STAT = 3'b100
	} fwps_op_t;
endpackage : fwps_pkg

// *** rtl/fwps_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module fwps_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_sys_i,
	input  wire logic         reset_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	initial begin
		if (W < 1) $error("fwps_sync: width below one");
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			meta_reg <= RST;
			q_o      <= RST;
		end else if (ce_i) begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : fwps_sync
`default_nettype wire

// *** rtl/fwps_top.sv ***
// write protection and status registers of a serial flash device
`timescale 1ns/100ps
`default_nettype none
`include "fwps_defs.svh"
module fwps_top #(
	parameter int PUW_CYCLES = `FWPS_PUW_US * 1000 / `FWPS_CLK_NS
) (
	input  wire logic               clk_sys_i,
	input  wire logic               reset_i,
	input  wire logic               ce_i,
	input  wire logic               spi_cs_n_i,
	input  wire logic               spi_sclk_i,
	input  wire logic               spi_si_i,
	output var  logic               spi_so_o,
	output var  logic               spi_so_oe_o,
	output var  logic               op_start_o,
	output var  fwps_pkg::fwps_op_t op_kind_o,
	output var  logic [31:0]        op_addr_o,
	output var  logic [7:0]         op_data_o,
	output var  logic               op_data_valid_o,
	input  wire logic               op_done_i,
	output var  logic               busy_o,
	output var  logic               power_down_o
);
	import fwps_pkg::*;
	initial begin
		if (PUW_CYCLES < 1 || PUW_CYCLES > 65535)
			$error("fwps_top: power-up delay out of range");
	end
	////////////////////////////////////////////////////////////////////////
	// pin sampling and edge detection
	logic       cs_n_s, sclk_s, si_s, sclk_d, cs_d;
	logic       sclk_rise, sclk_fall, cs_fall, cs_rise;
	fwps_sync #(.W(3), .RST(3'b101)) u_sync (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.ce_i      (ce_i),
		.d_i       ({spi_cs_n_i, spi_sclk_i, spi_si_i}),
		.q_o       ({cs_n_s, sclk_s, si_s})
	);
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else if (ce_i) begin
			sclk_d <= sclk_s;
			cs_d   <= cs_n_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
	assign cs_fall   = ~cs_n_s & cs_d;
	assign cs_rise   = cs_n_s & ~cs_d;
	////////////////////////////////////////////////////////////////////////
	// state
	fwps_link_t  state_reg;
	logic [2:0]  bit_cnt_reg, byte_cnt_reg;
	logic [7:0]  shift_reg, opc_reg, d1_reg, d2_reg;
	logic [31:0] addr_reg;
	logic [15:0] puw_cnt_reg;
	logic        puw_done_reg, wel_reg, busy_reg, pd_reg;
	logic [3:0]  bp_reg;
	logic [2:0]  lb_reg;
	logic        tb_reg, cmp_reg, srl_reg, wps_reg;
	logic        byte_done, gate, exec, addr_done, is_rd;
	logic [7:0]  byte_val, sr1, sr2, sr3, sr_sel;
	fwps_lock_if #(.IW(`FWPS_LIDX_W)) lk ();
	fwps_lock_mem u_lock (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.ce_i      (ce_i),
		.lk        (lk)
	);
	assign byte_done = sclk_rise && bit_cnt_reg == `FWPS_BIT_LAST
		&& (state_reg == LNK_OPC || state_reg == LNK_ARG);
	assign byte_val  = {shift_reg[6:0], si_s};
	assign exec      = cs_rise && state_reg == LNK_ARG;
	assign addr_done = byte_cnt_reg >= `FWPS_ADDR_BYTES;
	// filter applied when the opcode byte completes
	always_comb begin
		if (pd_reg)
			gate = byte_val != `FWPS_OP_RPD;
		else if (busy_reg)
			gate = !(byte_val == `FWPS_OP_RDSR1
				|| byte_val == `FWPS_OP_SUSP);
		else
			gate = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// serial framing
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg <= LNK_IDLE;
		end else if (ce_i) begin
			case (state_reg)
				LNK_IDLE: if (cs_fall) state_reg <= LNK_OPC;
				LNK_OPC: begin
					if (cs_n_s) state_reg <= LNK_IDLE;
					else if (byte_done) state_reg <= gate ? LNK_SKIP : LNK_ARG;
				end
				LNK_ARG, LNK_SKIP: if (cs_n_s) state_reg <= LNK_IDLE;
				default: state_reg <= LNK_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
			shift_reg    <= 8'h00;
			opc_reg      <= 8'h00;
			addr_reg     <= 32'h0;
			d1_reg       <= 8'h00;
			d2_reg       <= 8'h00;
		end else if (ce_i) begin
			if (cs_fall) begin
				bit_cnt_reg  <= 3'h0;
				byte_cnt_reg <= 3'h0;
			end else if (sclk_rise) begin
				shift_reg   <= byte_val;
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (byte_done && state_reg == LNK_OPC)
					opc_reg <= byte_val;
				if (byte_done && state_reg == LNK_ARG) begin
					if (byte_cnt_reg != `FWPS_BYTE_MAX)
						byte_cnt_reg <= byte_cnt_reg + 3'h1;
					if (!addr_done) addr_reg <= {addr_reg[23:0], byte_val};
					if (byte_cnt_reg == 3'h0) d1_reg <= byte_val;
					if (byte_cnt_reg == 3'h1) d2_reg <= byte_val;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// status read-out
	always_comb begin
		sr1 = 8'h00;
		sr2 = 8'h00;
		sr3 = 8'h00;
		sr1[`FWPS_SR1_BUSY] = busy_reg;
		sr1[`FWPS_SR1_WEL]  = wel_reg;
		sr1[`FWPS_SR1_BP_HI:`FWPS_SR1_BP_LO] = bp_reg;
		sr1[`FWPS_SR1_TB]   = tb_reg;
		sr2[`FWPS_SR2_SRL]  = srl_reg;
		sr2[`FWPS_SR2_QE]   = 1'b1;
		sr2[`FWPS_SR2_LB_HI:`FWPS_SR2_LB_LO] = lb_reg;
		sr2[`FWPS_SR2_CMP]  = cmp_reg;
		sr3[`FWPS_SR3_WPS]  = wps_reg;
		case (opc_reg)
			`FWPS_OP_RDSR2: sr_sel = sr2;
			`FWPS_OP_RDSR3: sr_sel = sr3;
			default:        sr_sel = sr1;
		endcase
	end
	assign is_rd = opc_reg == `FWPS_OP_RDSR1 || opc_reg == `FWPS_OP_RDSR2
		|| opc_reg == `FWPS_OP_RDSR3;
	assign spi_so_oe_o = state_reg == LNK_ARG && is_rd && !cs_n_s;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			spi_so_o <= 1'b0;
		end else if (ce_i && sclk_fall) begin
			spi_so_o <= sr_sel[~bit_cnt_reg];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// protection decision
	logic [8:0] blk;
	logic [9:0] sec, size;
	logic [3:0] bp_sh;
	logic       in_rng, bp_hit, bp_any, is_ce, prot, pe_ok;
	assign blk = addr_reg[`FWPS_BLK_HI:`FWPS_BLK_LO];
	assign sec = {6'h00, addr_reg[`FWPS_SEC_HI:`FWPS_SEC_LO]};
	always_comb begin
		bp_sh  = (bp_reg > `FWPS_BP_SAT) ? `FWPS_BP_SAT - 4'h1
			: bp_reg - 4'h1;
		size   = 10'h001 << bp_sh;
		in_rng = bp_reg != 4'h0 && (tb_reg ? {1'b0, blk} < size
			: {1'b0, blk} >= `FWPS_NBLK - size);
		bp_hit = in_rng ^ cmp_reg;
		bp_any = bp_reg != 4'h0 || cmp_reg;
		if (blk == 9'h000)
			lk.idx = sec;
		else if (blk == `FWPS_TOP_BLK)
			lk.idx = `FWPS_SEC_PER_END + sec;
		else
			lk.idx = {1'b0, blk} + `FWPS_BLK_BASE;
	end
	assign is_ce = opc_reg == `FWPS_OP_CE;
	assign prot  = wps_reg ? (is_ce ? lk.any : lk.rdata)
		: (is_ce ? bp_any : bp_hit);
	assign pe_ok = wel_reg && !prot && (is_ce || addr_done);
	assign lk.wr = exec && addr_done
		&& (opc_reg == `FWPS_OP_UNLK || opc_reg == `FWPS_OP_LOCK);
	assign lk.wval = opc_reg == `FWPS_OP_LOCK;
	////////////////////////////////////////////////////////////////////////
	// execution at deselect
	logic     start_ok, sr_ok;
	fwps_op_t kind_next;
	assign sr_ok = wel_reg && !srl_reg && byte_cnt_reg != 3'h0;
	always_comb begin
		start_ok  = 1'b0;
		kind_next = OPK_PROG;
		if (exec) begin
			case (opc_reg)
				`FWPS_OP_PP: start_ok = pe_ok;
				`FWPS_OP_SE: begin
					start_ok  = pe_ok;
					kind_next = OPK_SECT;
				end
				`FWPS_OP_BE: begin
					start_ok  = pe_ok;
					kind_next = OPK_BLK;
				end
				`FWPS_OP_CE: begin
					start_ok  = pe_ok;
					kind_next = OPK_CHIP;
				end
				`FWPS_OP_WRSR1, `FWPS_OP_WRSR2, `FWPS_OP_WRSR3: begin
					start_ok  = sr_ok;
					kind_next = OPK_STAT;
				end
				default: start_ok = 1'b0;
			endcase
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			puw_cnt_reg  <= 16'h0000;
			puw_done_reg <= 1'b0;
		end else if (ce_i && !puw_done_reg) begin
			puw_cnt_reg  <= puw_cnt_reg + 16'h0001;
			puw_done_reg <= puw_cnt_reg == 16'(PUW_CYCLES - 1);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			wel_reg <= 1'b0;
		end else if (ce_i) begin
			if (start_ok || (exec && opc_reg == `FWPS_OP_WRDI))
				wel_reg <= 1'b0;
			else if (exec && opc_reg == `FWPS_OP_WREN && puw_done_reg)
				wel_reg <= 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			busy_reg <= 1'b0;
		end else if (ce_i) begin
			if (start_ok) busy_reg <= 1'b1;
			else if (op_done_i) busy_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pd_reg <= 1'b0;
		end else if (ce_i && exec) begin
			if (opc_reg == `FWPS_OP_PD) pd_reg <= 1'b1;
			else if (opc_reg == `FWPS_OP_RPD) pd_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			bp_reg  <= 4'h0;
			tb_reg  <= 1'b0;
			cmp_reg <= 1'b0;
			srl_reg <= 1'b0;
			lb_reg  <= 3'h0;
			wps_reg <= 1'b0;
		end else if (ce_i && exec && sr_ok) begin
			case (opc_reg)
				`FWPS_OP_WRSR1: begin
					bp_reg <= d1_reg[`FWPS_SR1_BP_HI:`FWPS_SR1_BP_LO];
					tb_reg <= d1_reg[`FWPS_SR1_TB];
					if (byte_cnt_reg > 3'h1) begin
						srl_reg <= d2_reg[`FWPS_SR2_SRL];
						cmp_reg <= d2_reg[`FWPS_SR2_CMP];
						lb_reg  <= lb_reg | d2_reg[`FWPS_SR2_LB_HI:`FWPS_SR2_LB_LO];
					end
				end
				`FWPS_OP_WRSR2: begin
					srl_reg <= d1_reg[`FWPS_SR2_SRL];
					cmp_reg <= d1_reg[`FWPS_SR2_CMP];
					lb_reg  <= lb_reg | d1_reg[`FWPS_SR2_LB_HI:`FWPS_SR2_LB_LO];
				end
				`FWPS_OP_WRSR3: wps_reg <= d1_reg[`FWPS_SR3_WPS];
				default: wps_reg <= wps_reg;
			endcase
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			op_start_o      <= 1'b0;
			op_kind_o       <= OPK_PROG;
			op_addr_o       <= 32'h0;
			op_data_o       <= 8'h00;
			op_data_valid_o <= 1'b0;
		end else if (ce_i) begin
			op_start_o      <= start_ok;
			op_data_valid_o <= 1'b0;
			if (start_ok) begin
				op_kind_o <= kind_next;
				op_addr_o <= addr_reg;
			end
			if (byte_done && state_reg == LNK_ARG && addr_done
				&& opc_reg == `FWPS_OP_PP && pe_ok) begin
				op_data_o       <= byte_val;
				op_data_valid_o <= 1'b1;
			end
		end
	end
	assign busy_o       = busy_reg;
	assign power_down_o = pd_reg;
	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence s_unlock;
		ce_i && exec && addr_done && opc_reg == `FWPS_OP_UNLK ##1 ce_i;
	endsequence
	sequence s_start;
		ce_i && start_ok ##1 ce_i;
	endsequence
	property p_rst_quiet;
		@(posedge clk_sys_i) disable iff (1'b0)
		reset_i |=> !op_start_o && !wel_reg && !busy_reg;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("active in reset");
	property p_puw;
		!puw_done_reg |-> !wel_reg;
	endproperty
	a_puw: assert property (p_puw) else $error("latch set too early");
	property p_need_wel;
		op_start_o && $past(ce_i) |-> $past(wel_reg) && !wel_reg;
	endproperty
	a_need_wel: assert property (p_need_wel) else $error("no write enable");
	property p_pd;
		pd_reg && ce_i |=> !op_start_o && $stable(wel_reg);
	endproperty
	a_pd: assert property (p_pd) else $error("obeyed in power-down");
	property p_lock_ign;
		ce_i && exec && wps_reg && lk.rdata && !is_ce
			&& kind_next != OPK_STAT |=> !op_start_o;
	endproperty
	a_lock_ign: assert property (p_lock_ign) else $error("locked region hit");
	property p_pwr_lock;
		$past(reset_i) |-> lk.any && lk.rdata;
	endproperty
	a_pwr_lock: assert property (p_pwr_lock) else $error("lock not set");
	property p_unlock;
		s_unlock |=> !lk.rdata;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock failed");
	property p_bp_ign;
		ce_i && exec && !wps_reg && bp_hit && !is_ce
			&& kind_next != OPK_STAT |=> !op_start_o;
	endproperty
	a_bp_ign: assert property (p_bp_ign) else $error("range bits ignored");
	property p_sr_lock;
		ce_i && srl_reg |=> srl_reg && $stable(bp_reg);
	endproperty
	a_sr_lock: assert property (p_sr_lock) else $error("status lock lost");
	property p_busy_set;
		s_start |-> busy_reg && busy_o;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set");
	property p_busy_ign;
		busy_reg && ce_i |=> !op_start_o;
	endproperty
	a_busy_ign: assert property (p_busy_ign) else $error("busy not honoured");
	property p_busy_clr;
		busy_reg && op_done_i && ce_i && !start_ok |=> !busy_reg;
	endproperty
	a_busy_clr: assert property (p_busy_clr) else $error("busy stuck");
endmodule : fwps_top
`default_nettype wire
